// File: shared/rps_pkg.sv
// Purpose: constants for the receive-port select and status bank
// Assumes: four receive ports, 8-bit paged registers
// Notes:   offsets, field positions and reset values named once here
package rps_pkg;
    localparam int NPORT = 4;
    localparam int NCTX  = 5;

    // register offsets
    localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;
    localparam logic [7:0] ADDR_STS1     = 8'h4d;
    localparam logic [7:0] ADDR_STS2     = 8'h4e;
    localparam logic [7:0] ADDR_PAR_HI   = 8'h55;
    localparam logic [7:0] ADDR_PAR_LO   = 8'h56;

    // port select fields
    localparam int SEL_WE_LSB   = 0;
    localparam int SEL_READ_LSB = 4;
    localparam int SEL_PHYS_LSB = 6;
    localparam logic [5:0] SEL_LOCAL_RST = 6'h00;

    // first status register fields
    localparam int S1_PORT_LSB = 6;
    localparam int S1_CRC      = 5;
    localparam int S1_LOCKCHG  = 4;
    localparam int S1_SEQ      = 3;
    localparam int S1_PAR      = 2;
    localparam int S1_PASS     = 1;
    localparam int S1_LOCK     = 0;

    // second status register fields
    localparam int S2_UNSTEADY = 7;
    localparam int S2_CHG      = 6;
    localparam int S2_ENC      = 5;
    localparam int S2_OVF      = 4;

    // link events crossing to the system clock
    localparam int NEV         = 7;
    localparam int EV_CRC      = 0;
    localparam int EV_SEQ      = 1;
    localparam int EV_UNSTEADY = 2;
    localparam int EV_CHG      = 3;
    localparam int EV_ENC      = 4;
    localparam int EV_OVF      = 5;
    localparam int EV_PAR      = 6;

    // sticky flags
    localparam int NFL         = 7;
    localparam int FL_CRC      = 0;
    localparam int FL_LOCKCHG  = 1;
    localparam int FL_SEQ      = 2;
    localparam int FL_UNSTEADY = 3;
    localparam int FL_CHG      = 4;
    localparam int FL_ENC      = 5;
    localparam int FL_OVF      = 6;
    localparam logic [NFL-1:0] STS1_COR_MASK = 7'h07;
    localparam logic [NFL-1:0] STS2_COR_MASK = 7'h78;
    localparam logic [NFL-1:0] FLAG_RST      = 7'h00;

    localparam logic [15:0] PAR_CNT_RST   = 16'h0000;
    localparam logic [15:0] PAR_CNT_MAX   = 16'hffff;
    localparam logic [7:0]  ENC_LIMIT_MIN = 8'h01;
endpackage

// File: src/rps_status_bank.sv
// Purpose: receive-port readback/write select and per-port status flags
// Assumes: link events are one-cycle pulses on clk_link; levels on clk_link
// Notes:   read data registered, valid one cycle after the read strobe
// Contract
// - two-bit selector picks readback port block
// - selector defaults: local zero, back-channel own port
// - four write enables gate paged register writes
// - enables reset zero; back-channel own port one
// - status one reports selected read port
// - control channel crc fault sticky, clear-on-read
// - lock change flag sticky, clear-on-read
// - control channel sequence fault sticky, clear-on-read
// - parity flag while count exceeds limit
// - live qualification pass bit
// - live receiver locked bit
// - line width unsteady sticky until read
// - line width changed sticky, clear-on-read
// - encoding fault sticky, gated by fault counting
// - fifo overflow sticky, cleared reading status two
// - low count read clears both count bytes
`timescale 1ns/1ps
`default_nettype none
module rps_status_bank
    import rps_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    input  wire logic                 clk_link,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic                 reg_from_bc,
    input  wire logic [1:0]           reg_bc_port,
    output logic [7:0]                reg_rdata,
    output logic                      reg_rvalid,
    output logic [rps_pkg::NPORT-1:0] paged_wr_en,
    output logic [1:0]                paged_rd_port,
    input  wire logic [15:0]          parity_limit,
    input  wire logic                 link_fault_count_en,
    input  wire logic [7:0]           link_fault_limit,
    input  wire logic [rps_pkg::NPORT-1:0] receiver_locked,
    input  wire logic [rps_pkg::NPORT-1:0] qualification_pass,
    input  wire logic [rps_pkg::NPORT-1:0] ctrl_channel_crc_fault,
    input  wire logic [rps_pkg::NPORT-1:0] ctrl_channel_sequence_fault,
    input  wire logic [rps_pkg::NPORT-1:0] line_width_unsteady,
    input  wire logic [rps_pkg::NPORT-1:0] line_width_changed,
    input  wire logic [rps_pkg::NPORT-1:0] link_encoding_fault,
    input  wire logic [rps_pkg::NPORT-1:0] fifo_overflow,
    input  wire logic [rps_pkg::NPORT-1:0] parity_fault
);
    import rps_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // context 0 local host, 1..4 back channel of ports 0..3
    function automatic logic [2:0] ctx_of(input logic bc, input logic [1:0] port);
        ctx_of = bc ? (3'(port) + 3'd1) : 3'd0;
    endfunction

    logic [5:0] sel_q [NCTX];
    logic [2:0] cur_ctx;
    logic [7:0] sts1_b [NPORT];
    logic [7:0] sts2_b [NPORT];
    logic [7:0] parh_b [NPORT];
    logic [7:0] parl_b [NPORT];
    logic [7:0] rdata_d;
    logic       enc_armed;
    logic       paged_access;

    assign cur_ctx       = ctx_of(reg_from_bc, reg_bc_port);
    assign paged_rd_port = sel_q[cur_ctx][SEL_READ_LSB +: 2];
    assign paged_access  = (reg_addr != ADDR_PORT_SEL);
    assign paged_wr_en   = (reg_wr && paged_access) ? sel_q[cur_ctx][3:0] : 4'h0;
    assign enc_armed     = link_fault_count_en && (link_fault_limit > ENC_LIMIT_MIN);

    // one select context per access source
    for (genvar c = 0; c < NCTX; c++) begin : g_ctx
        localparam logic [5:0] CTX_RST = (c == 0) ? SEL_LOCAL_RST :
            {2'(c - 1), 4'(4'h1 << (c - 1))};
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                sel_q[c] <= CTX_RST;
            end else if (reg_wr && reg_addr == ADDR_PORT_SEL && cur_ctx == 3'(c)) begin
                sel_q[c] <= reg_wdata[5:0];
            end
        end
    end

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        localparam logic [1:0] PN = 2'(p);
        logic [NEV-1:0] link_evt;
        logic [NEV-1:0] tgl_q;
        logic [NEV-1:0] s1_q;
        logic [NEV-1:0] s2_q;
        logic [NEV-1:0] s3_q;
        logic [NEV-1:0] evt;
        logic [2:0]     lock_q;
        logic [1:0]     pass_q;
        logic [NFL-1:0] flag_q;
        logic [NFL-1:0] set;
        logic [NFL-1:0] clr;
        logic [15:0]    cnt_q;
        logic           rd_sel;
        logic           cnt_clr;
        logic           par_flag;

        assign link_evt[EV_CRC]      = ctrl_channel_crc_fault[p];
        assign link_evt[EV_SEQ]      = ctrl_channel_sequence_fault[p];
        assign link_evt[EV_UNSTEADY] = line_width_unsteady[p];
        assign link_evt[EV_CHG]      = line_width_changed[p];
        assign link_evt[EV_ENC]      = link_encoding_fault[p];
        assign link_evt[EV_OVF]      = fifo_overflow[p];
        assign link_evt[EV_PAR]      = parity_fault[p];

        // event toggles in the link domain
        always_ff @(posedge clk_link or negedge resetn) begin
            if (!resetn) begin
                tgl_q <= '0;
            end else begin
                tgl_q <= tgl_q ^ link_evt;
            end
        end

        // toggle synchroniser, edge from second and third stages
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                s1_q <= '0;
                s2_q <= '0;
                s3_q <= '0;
            end else begin
                s1_q <= tgl_q;
                s2_q <= s1_q;
                s3_q <= s2_q;
            end
        end
        assign evt = s2_q ^ s3_q;

        // live levels, lock keeps a third stage for change detect
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                lock_q <= '0;
                pass_q <= '0;
            end else begin
                lock_q <= {lock_q[1:0], receiver_locked[p]};
                pass_q <= {pass_q[0], qualification_pass[p]};
            end
        end

        assign rd_sel  = reg_rd && paged_rd_port == PN;
        assign cnt_clr = (rd_sel && reg_addr == ADDR_PAR_LO) || (lock_q[1] && !lock_q[2]);

        always_comb begin
            set              = '0;
            set[FL_CRC]      = evt[EV_CRC];
            set[FL_LOCKCHG]  = lock_q[1] ^ lock_q[2];
            set[FL_SEQ]      = evt[EV_SEQ];
            set[FL_UNSTEADY] = evt[EV_UNSTEADY];
            set[FL_CHG]      = evt[EV_CHG];
            set[FL_ENC]      = evt[EV_ENC] && enc_armed;
            set[FL_OVF]      = evt[EV_OVF];
            clr              = '0;
            if (rd_sel && reg_addr == ADDR_STS1) begin
                clr = STS1_COR_MASK;
            end else if (rd_sel && reg_addr == ADDR_STS2) begin
                clr = STS2_COR_MASK;
            end
        end

        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                flag_q <= FLAG_RST;
            end else begin
                flag_q <= set | (flag_q & ~clr);
            end
        end

        // parity count, saturating, cleared by low byte read or lock gain
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                cnt_q <= PAR_CNT_RST;
            end else if (cnt_clr) begin
                cnt_q <= evt[EV_PAR] ? 16'h0001 : PAR_CNT_RST;
            end else if (evt[EV_PAR] && cnt_q != PAR_CNT_MAX) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
        assign par_flag = cnt_q > parity_limit;

        always_comb begin
            sts1_b[p]                     = 8'h00;
            sts1_b[p][S1_PORT_LSB +: 2]   = paged_rd_port;
            sts1_b[p][S1_CRC]             = flag_q[FL_CRC];
            sts1_b[p][S1_LOCKCHG]         = flag_q[FL_LOCKCHG];
            sts1_b[p][S1_SEQ]             = flag_q[FL_SEQ];
            sts1_b[p][S1_PAR]             = par_flag;
            sts1_b[p][S1_PASS]            = pass_q[1];
            sts1_b[p][S1_LOCK]            = lock_q[1];
            sts2_b[p]                     = 8'h00;
            sts2_b[p][S2_UNSTEADY]        = flag_q[FL_UNSTEADY];
            sts2_b[p][S2_CHG]             = flag_q[FL_CHG];
            sts2_b[p][S2_ENC]             = flag_q[FL_ENC];
            sts2_b[p][S2_OVF]             = flag_q[FL_OVF];
            parh_b[p]                     = cnt_q[15:8];
            parl_b[p]                     = cnt_q[7:0];
        end

        sequence s_rd_sts1;
            reg_rd && reg_addr == ADDR_STS1 && paged_rd_port == PN;
        endsequence
        sequence s_rd_sts2;
            reg_rd && reg_addr == ADDR_STS2 && paged_rd_port == PN;
        endsequence

        property p_crc_cor;
            s_rd_sts1 and (!evt[EV_CRC]) |=> !flag_q[FL_CRC];
        endproperty
        a_crc_cor: assert property (p_crc_cor) else $error("crc flag not cleared");

        property p_seq_set_wins;
            s_rd_sts1 and evt[EV_SEQ] |=> flag_q[FL_SEQ] && reg_rdata[S1_SEQ] == $past(flag_q[FL_SEQ]);
        endproperty
        a_seq_set_wins: assert property (p_seq_set_wins) else $error("seq event lost");

        property p_lock_change;
            (lock_q[1] != lock_q[2]) |=> flag_q[FL_LOCKCHG];
        endproperty
        a_lock_change: assert property (p_lock_change) else $error("lock change missed");

        property p_cor_old_value;
            flag_q[FL_OVF] and s_rd_sts2 |=> reg_rvalid && reg_rdata[S2_OVF];
        endproperty
        a_cor_old_value: assert property (p_cor_old_value) else $error("old flag not returned");

        property p_ovf_hold;
            flag_q[FL_OVF] && !(reg_rd && paged_rd_port == PN) |=> flag_q[FL_OVF];
        endproperty
        a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");

        property p_enc_gate;
            evt[EV_ENC] && !enc_armed && !flag_q[FL_ENC] |=> !flag_q[FL_ENC];
        endproperty
        a_enc_gate: assert property (p_enc_gate) else $error("encode flag not gated");

        property p_par_clear;
            reg_rd && reg_addr == ADDR_PAR_LO && paged_rd_port == PN && !evt[EV_PAR]
                |=> cnt_q == PAR_CNT_RST && !par_flag;
        endproperty
        a_par_clear: assert property (p_par_clear) else $error("parity count not cleared");

        property p_lock_live;
            receiver_locked[p] [*3] |-> lock_q[1];
        endproperty
        a_lock_live: assert property (p_lock_live) else $error("lock bit not live");

        property p_lockchg_cor;
            s_rd_sts1 and (lock_q[1] == lock_q[2]) |=> !flag_q[FL_LOCKCHG];
        endproperty
        a_lockchg_cor: assert property (p_lockchg_cor) else $error("lock change kept");

        property p_unsteady_cor;
            s_rd_sts2 and (!evt[EV_UNSTEADY]) |=> !flag_q[FL_UNSTEADY];
        endproperty
        a_unsteady_cor: assert property (p_unsteady_cor) else $error("unsteady kept");

        property p_pass_live;
            qualification_pass[p] [*3] |-> pass_q[1];
        endproperty
        a_pass_live: assert property (p_pass_live) else $error("pass bit not live");

        property p_par_lock_clear;
            lock_q[1] && !lock_q[2] && !evt[EV_PAR] |=> cnt_q == PAR_CNT_RST;
        endproperty
        a_par_lock_clear: assert property (p_par_lock_clear) else $error("count kept");
    end

    // read mux, registered answer
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            ADDR_PORT_SEL: begin
                rdata_d = {(reg_from_bc ? reg_bc_port : 2'b00), sel_q[cur_ctx]};
            end
            ADDR_STS1: begin
                rdata_d = sts1_b[paged_rd_port];
            end
            ADDR_STS2: begin
                rdata_d = sts2_b[paged_rd_port];
            end
            ADDR_PAR_HI: begin
                rdata_d = parh_b[paged_rd_port];
            end
            ADDR_PAR_LO: begin
                rdata_d = parl_b[paged_rd_port];
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= reg_rd ? rdata_d : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    property p_read_port_field;
        reg_rd && reg_addr == ADDR_STS1 |=> reg_rdata[7:6] == $past(paged_rd_port);
    endproperty
    a_read_port_field: assert property (p_read_port_field) else $error("port field wrong");

    property p_wr_gate;
        reg_wr && reg_addr != ADDR_PORT_SEL |-> paged_wr_en == sel_q[cur_ctx][3:0];
    endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("write enables wrong");

    property p_sel_write;
        reg_wr && reg_addr == ADDR_PORT_SEL ##1 !reg_wr
            |-> paged_rd_port == $past(reg_wdata[5:4]) || cur_ctx != $past(cur_ctx);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("read select not stored");

    property p_sel_reset;
        $rose(resetn) |-> sel_q[0] == SEL_LOCAL_RST && sel_q[1][1:0] == 2'b01 && sel_q[4][5:4] == 2'b11;
    endproperty
    a_sel_reset: assert property (@(posedge clk_sys) p_sel_reset) else $error("select reset wrong");

    property p_sts2_reserved;
        reg_rd && reg_addr == ADDR_STS2 |=> reg_rdata[3:0] == 4'h0;
    endproperty
    a_sts2_reserved: assert property (p_sts2_reserved) else $error("reserved bits set");

    property p_wr_idle;
        !reg_wr |-> paged_wr_en == 4'h0;
    endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("write enables without write");

    property p_sel_isolate;
        reg_wr && reg_addr == ADDR_PORT_SEL && cur_ctx != 3'd0 |=> $stable(sel_q[0]);
    endproperty
    a_sel_isolate: assert property (p_sel_isolate) else $error("local select disturbed");
endmodule
`default_nettype wire

// File: test/rps_link_src.sv
// Purpose: link-side source of per-port status levels and event pulses
// Assumes: pulses last one clk_link cycle, launched just after its edge
// Notes:   driven on request from the testbench through tasks
`timescale 1ns/1ps
`default_nettype none
module rps_link_src
    import rps_pkg::*;
(
    input  wire logic                 clk_link,
    output logic [rps_pkg::NPORT-1:0] locked,
    output logic [rps_pkg::NPORT-1:0] pass,
    output logic [rps_pkg::NEV-1:0][rps_pkg::NPORT-1:0] ev
);
    import rps_pkg::*;
    initial begin
        locked = 4'h0;
        pass   = 4'h0;
        ev     = '0;
    end

    // one-cycle event on one port, spaced well apart
    task automatic pulse(input int kind, input int port);
        @(posedge clk_link);
        #1 ev[kind][port] = 1'b1;
        @(posedge clk_link);
        #1 ev[kind][port] = 1'b0;
        @(posedge clk_link);
    endtask

    // live levels change only after a link edge
    task automatic set_lvl(input logic [3:0] lk, input logic [3:0] ps);
        @(posedge clk_link);
        #1 locked = lk;
        pass = ps;
    endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench for the receive-port select and status bank
// Assumes: inputs driven at falling clk_sys edge, link source on clk_link
// Notes:   flags are given twenty system cycles to cross domains
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rps_pkg::*;
    logic clk_sys = 1'b0, clk_link = 1'b0, resetn = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_from_bc = 1'b0;
    logic [1:0]  reg_bc_port = 2'h0;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [3:0]  paged_wr_en, pwe;
    logic [1:0]  paged_rd_port;
    logic [15:0] parity_limit = 16'h0001;
    logic        fc_en = 1'b0;
    logic [7:0]  fc_limit = 8'h01;
    logic [3:0]  lk, ps;
    logic [NEV-1:0][NPORT-1:0] ev;
    int          fail_count = 0, n_tests = 0;

    always #5 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #24 clk_link = ~clk_link;
    end

    rps_link_src u_src (.clk_link(clk_link), .locked(lk), .pass(ps), .ev(ev));

    rps_status_bank u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_from_bc(reg_from_bc), .reg_bc_port(reg_bc_port), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .paged_wr_en(paged_wr_en), .paged_rd_port(paged_rd_port),
        .parity_limit(parity_limit), .link_fault_count_en(fc_en),
        .link_fault_limit(fc_limit), .receiver_locked(lk), .qualification_pass(ps),
        .ctrl_channel_crc_fault(ev[EV_CRC]), .ctrl_channel_sequence_fault(ev[EV_SEQ]),
        .line_width_unsteady(ev[EV_UNSTEADY]), .line_width_changed(ev[EV_CHG]),
        .link_encoding_fault(ev[EV_ENC]), .fifo_overflow(ev[EV_OVF]),
        .parity_fault(ev[EV_PAR]));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic bc, input logic [1:0] p,
                      input logic [7:0] exp, input string nm);
        @(negedge clk_sys);
        reg_addr = a;
        reg_from_bc = bc;
        reg_bc_port = p;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk({nm, " valid"}, 8'h01, {7'h00, reg_rvalid});
        chk(nm, exp, reg_rdata);
    endtask

    task automatic wr(input logic [7:0] a, input logic bc, input logic [1:0] p,
                      input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_from_bc = bc;
        reg_bc_port = p;
        reg_wdata = d;
        reg_wr = 1'b1;
        #1 pwe = paged_wr_en;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic settle();
        repeat (20) @(negedge clk_sys);
    endtask

    task automatic t_reset();
        rd(ADDR_PORT_SEL, 1'b0, 2'h0, 8'h00, "sel local");
        rd(ADDR_PORT_SEL, 1'b1, 2'h2, 8'ha4, "sel bc2");
        chk("rd port bc2", 8'h02, {6'h00, paged_rd_port});
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h00, "sts1 reset");
        rd(8'h10, 1'b0, 2'h0, 8'h00, "unmapped");
    endtask

    task automatic t_select();
        wr(ADDR_PORT_SEL, 1'b0, 2'h0, 8'hdb);
        chk("no paged we", 8'h00, {4'h0, pwe});
        rd(ADDR_PORT_SEL, 1'b0, 2'h0, 8'h1b, "sel written");
        chk("rd port", 8'h01, {6'h00, paged_rd_port});
        wr(8'h20, 1'b0, 2'h0, 8'h55);
        chk("paged we", 8'h0b, {4'h0, pwe});
        rd(ADDR_PORT_SEL, 1'b1, 2'h3, 8'hf8, "sel bc3");
        wr(ADDR_STS1, 1'b0, 2'h0, 8'hff);
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h40, "sts1 port");
        wr(8'h20, 1'b1, 2'h2, 8'h00);
        chk("bc2 paged we", 8'h04, {4'h0, pwe});
        wr(ADDR_PORT_SEL, 1'b1, 2'h2, 8'h3f);
        rd(ADDR_PORT_SEL, 1'b1, 2'h2, 8'hbf, "sel bc2 written");
        rd(ADDR_PORT_SEL, 1'b0, 2'h0, 8'h1b, "sel local kept");
    endtask

    task automatic t_flags();
        u_src.set_lvl(4'h2, 4'h2);
        u_src.pulse(EV_CRC, 1);
        u_src.pulse(EV_SEQ, 1);
        u_src.pulse(EV_CRC, 0);
        settle();
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h7b, "sts1 set");
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h43, "sts1 cleared");
        rd(ADDR_STS1, 1'b1, 2'h0, 8'h20, "sts1 port0");
    endtask

    task automatic t_sts2();
        fc_en = 1'b1;
        fc_limit = 8'h02;
        u_src.pulse(EV_UNSTEADY, 1);
        u_src.pulse(EV_CHG, 1);
        u_src.pulse(EV_ENC, 1);
        u_src.pulse(EV_OVF, 1);
        settle();
        rd(ADDR_STS2, 1'b0, 2'h0, 8'hf0, "sts2 set");
        rd(ADDR_STS2, 1'b0, 2'h0, 8'h00, "sts2 cleared");
        @(negedge clk_sys);
        fc_limit = 8'h01;
        u_src.pulse(EV_ENC, 1);
        settle();
        rd(ADDR_STS2, 1'b0, 2'h0, 8'h00, "enc unarmed");
    endtask

    task automatic t_parity();
        u_src.pulse(EV_PAR, 1);
        settle();
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h43, "par at limit");
        u_src.pulse(EV_PAR, 1);
        settle();
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h47, "par over");
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h47, "par live");
        rd(ADDR_PAR_HI, 1'b0, 2'h0, 8'h00, "par hi");
        rd(ADDR_PAR_LO, 1'b0, 2'h0, 8'h02, "par lo");
        rd(ADDR_PAR_LO, 1'b0, 2'h0, 8'h00, "par lo clr");
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h43, "par cleared");
    endtask

    task automatic t_collide();
        fork
            u_src.pulse(EV_SEQ, 1);
            begin
                @(negedge ev[EV_SEQ][1]);
                repeat (2) @(posedge clk_sys);
                rd(ADDR_STS1, 1'b0, 2'h0, 8'h43, "seq on clear");
            end
        join
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h4b, "seq kept");
    endtask

    task automatic t_lock_par();
        u_src.pulse(EV_PAR, 1);
        u_src.pulse(EV_PAR, 1);
        settle();
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h47, "par before relock");
        u_src.set_lvl(4'h0, 4'h2);
        u_src.set_lvl(4'h2, 4'h2);
        settle();
        rd(ADDR_STS1, 1'b0, 2'h0, 8'h53, "par after relock");
        rd(ADDR_PAR_LO, 1'b0, 2'h0, 8'h00, "par lo relock");
    endtask

    task automatic finish_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        t_reset();
        t_select();
        t_flags();
        t_sts2();
        t_parity();
        t_collide();
        t_lock_par();
        finish_test();
    end
endmodule
`default_nettype wire
